// File: inc/fsc_pkg.sv
// constants, register map and timing counts for the flash sequence controller
package fsc_pkg;

    // ***********************************************************
    // clock and flash timing
    // ***********************************************************
    localparam int CLK_MHZ = 100;
    localparam int T_ACC_NS = 70;
    localparam int T_WP_NS = 50;
    localparam int T_WPH_NS = 30;
    localparam int T_BUSY_NS = 90;
    localparam int T_RP_NS = 500;
    localparam int T_RH_NS = 50;
    // four flops from pin to sampled value, plus one edge for a pin change on a clock edge
    localparam int SYNC_LAT = 5;

    // least times: round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ACC_CYC = ns_to_cyc(T_ACC_NS) + SYNC_LAT;
    localparam int WP_CYC = ns_to_cyc(T_WP_NS);
    localparam int WPH_CYC = ns_to_cyc(T_WPH_NS);
    localparam int BUSY_CYC = ns_to_cyc(T_BUSY_NS);
    localparam int RP_CYC = ns_to_cyc(T_RP_NS);
    localparam int RH_CYC = ns_to_cyc(T_RH_NS);
    localparam int CNT_W = 16;

    // ***********************************************************
    // flash geometry
    // ***********************************************************
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int SEQ_DEPTH = 6;

    // ***********************************************************
    // register map
    // ***********************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_LEN = 8'h0C;
    localparam logic [7:0] OFF_SEQ0 = 8'h10;

    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_STBY_BIT = 3;
    localparam int CTRL_TGL_BIT = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0008;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] LEN_RST = 32'h0000_0001;

    localparam int SEQ_DATA_LSB = 0;
    localparam int SEQ_ADDR_LSB = 8;

    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_RDY_BIT = 2;
    localparam int STAT_DATA_LSB = 8;

    typedef enum logic [1:0] {
        OP_READ,
        OP_SEQ,
        OP_SEQ_WAIT,
        OP_RESET
    } fsc_op_type;

endpackage

// File: logic/fsc_pin_sync.sv
// three-stage input synchroniser; output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module fsc_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_out <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    sync_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/fsc_ctrl.sv
// host-side flash sequence controller: apb registers in, flash bus pins out
// Overview of operation
// - commands go out as plain bus write cycles
// - sequence length one to six (SEQ_DEPTH) writes
// - suspend is a one-write sequence, no wait
// - standby bit keeps chip select high while idle
// - separate strobes; output enable only on reads
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module fsc_ctrl #(
    parameter int SEQ_DEPTH = fsc_pkg::SEQ_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [fsc_pkg::ADDR_W-1:0] byte_address_lines,
    output logic [fsc_pkg::DATA_W-1:0] byte_data_out,
    output logic byte_data_oe_n,
    input wire logic [fsc_pkg::DATA_W-1:0] byte_data_in,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_en_n,
    output logic flash_reset_n,
    input wire logic ready_busy_out
);
    localparam int IDX_W = $clog2(SEQ_DEPTH + 1);

    initial begin
        if (SEQ_DEPTH < 1 || SEQ_DEPTH > 16) begin
            $error("SEQ_DEPTH must lie in 1..16");
        end
    end

    // ***********************************************************
    // state and storage
    // ***********************************************************
    typedef enum {
        ST_IDLE, ST_RD_ACC, ST_RD_END, ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
        ST_WR_GAP, ST_BUSY_DLY, ST_WAIT_RDY, ST_RST_LOW, ST_RST_REC
    } fsc_state_type;

    fsc_state_type state_r;
    logic [31:0] ctrl_r;
    logic [fsc_pkg::ADDR_W-1:0] rd_addr_r;
    logic [IDX_W-1:0] len_r;
    logic [fsc_pkg::ADDR_W-1:0] seq_addr_r [SEQ_DEPTH];
    logic [fsc_pkg::DATA_W-1:0] seq_data_r [SEQ_DEPTH];
    logic [IDX_W-1:0] idx_r;
    logic [fsc_pkg::CNT_W-1:0] cnt_r;
    logic [fsc_pkg::DATA_W-1:0] rd_data_r;
    logic [fsc_pkg::DATA_W-1:0] prev_r;
    logic prev_vld_r;
    logic poll_rd_r;
    logic done_r;
    logic [fsc_pkg::DATA_W-1:0] dq_sync;
    logic rdy_sync;
    logic wr_acc;
    logic go;
    fsc_pkg::fsc_op_type go_op;

    fsc_pin_sync #(.WIDTH(fsc_pkg::DATA_W)) u_dq_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(byte_data_in),
        .sync_out(dq_sync)
    );

    fsc_pin_sync #(.WIDTH(1)) u_rdy_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(ready_busy_out),
        .sync_out(rdy_sync)
    );

    function automatic logic [fsc_pkg::CNT_W-1:0] cyc(input int n);
        return fsc_pkg::CNT_W'(n - 1);
    endfunction

    function automatic logic seq_hit(input logic [7:0] a);
        return (a >= fsc_pkg::OFF_SEQ0) && (a < fsc_pkg::OFF_SEQ0 + 8'(4 * SEQ_DEPTH))
            && (a[1:0] == 2'b00);
    endfunction

    function automatic int seq_idx(input logic [7:0] a);
        return int'((a - fsc_pkg::OFF_SEQ0) >> 2);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == fsc_pkg::OFF_CTRL) || (a == fsc_pkg::OFF_ADDR)
            || (a == fsc_pkg::OFF_STAT) || (a == fsc_pkg::OFF_LEN) || seq_hit(a);
    endfunction

    assign wr_acc = psel && penable && pready && pwrite && mapped(paddr);
    assign go = wr_acc && (paddr == fsc_pkg::OFF_CTRL) && pwdata[fsc_pkg::CTRL_GO_BIT];
    assign go_op = fsc_pkg::fsc_op_type'(pwdata[fsc_pkg::CTRL_OP_LSB +: 2]);

    // ***********************************************************
    // apb slave
    // ***********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !mapped(paddr);
            prdata <= 32'h0000_0000;
            if (!pwrite) begin
                if (paddr == fsc_pkg::OFF_CTRL) begin
                    prdata <= ctrl_r;
                end else if (paddr == fsc_pkg::OFF_ADDR) begin
                    prdata[fsc_pkg::ADDR_W-1:0] <= rd_addr_r;
                end else if (paddr == fsc_pkg::OFF_LEN) begin
                    prdata[IDX_W-1:0] <= len_r;
                end else if (paddr == fsc_pkg::OFF_STAT) begin
                    prdata[fsc_pkg::STAT_BUSY_BIT] <= (state_r != ST_IDLE);
                    prdata[fsc_pkg::STAT_DONE_BIT] <= done_r;
                    prdata[fsc_pkg::STAT_RDY_BIT] <= rdy_sync;
                    prdata[fsc_pkg::STAT_DATA_LSB +: fsc_pkg::DATA_W] <= rd_data_r;
                end else if (seq_hit(paddr)) begin
                    prdata[fsc_pkg::SEQ_DATA_LSB +: fsc_pkg::DATA_W] <= seq_data_r[seq_idx(paddr)];
                    prdata[fsc_pkg::SEQ_ADDR_LSB +: fsc_pkg::ADDR_W] <= seq_addr_r[seq_idx(paddr)];
                end
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= fsc_pkg::CTRL_RST;
            rd_addr_r <= fsc_pkg::ADDR_RST[fsc_pkg::ADDR_W-1:0];
            len_r <= fsc_pkg::LEN_RST[IDX_W-1:0];
            for (int i = 0; i < SEQ_DEPTH; i++) begin
                seq_addr_r[i] <= '0;
                seq_data_r[i] <= '0;
            end
        end else if (wr_acc) begin
            if (paddr == fsc_pkg::OFF_CTRL) begin
                ctrl_r <= {pwdata[31:1], 1'b0};
            end else if (paddr == fsc_pkg::OFF_ADDR) begin
                rd_addr_r <= pwdata[fsc_pkg::ADDR_W-1:0];
            end else if (paddr == fsc_pkg::OFF_LEN) begin
                // lengths of 1..SEQ_DEPTH; other values of the low IDX_W bits clamp to the nearest legal value
                if (pwdata[IDX_W-1:0] == '0) begin
                    len_r <= IDX_W'(1);
                end else if (pwdata[IDX_W-1:0] > IDX_W'(SEQ_DEPTH)) begin
                    len_r <= IDX_W'(SEQ_DEPTH);
                end else begin
                    len_r <= pwdata[IDX_W-1:0];
                end
            end else if (seq_hit(paddr)) begin
                seq_data_r[seq_idx(paddr)] <= pwdata[fsc_pkg::SEQ_DATA_LSB +: fsc_pkg::DATA_W];
                seq_addr_r[seq_idx(paddr)] <= pwdata[fsc_pkg::SEQ_ADDR_LSB +: fsc_pkg::ADDR_W];
            end
        end
    end

    // ***********************************************************
    // flash bus sequencer
    // ***********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            idx_r <= '0;
            cnt_r <= '0;
            rd_data_r <= '0;
            prev_r <= '0;
            prev_vld_r <= 1'b0;
            poll_rd_r <= 1'b0;
            done_r <= 1'b0;
            byte_address_lines <= '0;
            byte_data_out <= '0;
            byte_data_oe_n <= 1'b1;
            chip_sel_n <= 1'b1;
            out_en_n <= 1'b1;
            write_en_n <= 1'b1;
            flash_reset_n <= 1'b1;
        end else if (go && go_op == fsc_pkg::OP_RESET) begin
            // accepted in any state: drops every strobe and pulses reset
            done_r <= 1'b0;
            byte_data_oe_n <= 1'b1;
            chip_sel_n <= 1'b1;
            out_en_n <= 1'b1;
            write_en_n <= 1'b1;
            flash_reset_n <= 1'b0;
            cnt_r <= cyc(fsc_pkg::RP_CYC);
            state_r <= ST_RST_LOW;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    chip_sel_n <= ctrl_r[fsc_pkg::CTRL_STBY_BIT];
                    if (go) begin
                        done_r <= 1'b0;
                        idx_r <= '0;
                        prev_vld_r <= 1'b0;
                        if (go_op == fsc_pkg::OP_READ) begin
                            poll_rd_r <= 1'b0;
                            byte_address_lines <= rd_addr_r;
                            chip_sel_n <= 1'b0;
                            out_en_n <= 1'b0;
                            cnt_r <= cyc(fsc_pkg::ACC_CYC);
                            state_r <= ST_RD_ACC;
                        end else begin
                            chip_sel_n <= 1'b1;
                            state_r <= ST_WR_SETUP;
                        end
                    end
                end
                ST_RD_ACC: begin
                    if (cnt_r == '0) begin
                        rd_data_r <= dq_sync;
                        out_en_n <= 1'b1;
                        chip_sel_n <= 1'b1;
                        cnt_r <= cyc(fsc_pkg::WPH_CYC);
                        state_r <= ST_RD_END;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_RD_END: begin
                    if (cnt_r != '0) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else if (poll_rd_r && !(prev_vld_r
                            && prev_r[fsc_pkg::TOGGLE_BIT] == rd_data_r[fsc_pkg::TOGGLE_BIT])) begin
                        // no earlier read to compare yet, or bit still toggling: read again
                        prev_r <= rd_data_r;
                        prev_vld_r <= 1'b1;
                        chip_sel_n <= 1'b0;
                        out_en_n <= 1'b0;
                        cnt_r <= cyc(fsc_pkg::ACC_CYC);
                        state_r <= ST_RD_ACC;
                    end else begin
                        done_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_WR_SETUP: begin
                    byte_address_lines <= seq_addr_r[idx_r];
                    byte_data_out <= seq_data_r[idx_r];
                    byte_data_oe_n <= 1'b0;
                    chip_sel_n <= 1'b0;
                    out_en_n <= 1'b1;
                    cnt_r <= cyc(fsc_pkg::WP_CYC);
                    state_r <= ST_WR_PULSE;
                end
                ST_WR_PULSE: begin
                    write_en_n <= 1'b0;
                    if (cnt_r == '0) begin
                        state_r <= ST_WR_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_WR_HOLD: begin
                    // address and data stay one cycle past the rising strobe
                    write_en_n <= 1'b1;
                    cnt_r <= cyc(fsc_pkg::WPH_CYC);
                    state_r <= ST_WR_GAP;
                end
                ST_WR_GAP: begin
                    chip_sel_n <= 1'b1;
                    byte_data_oe_n <= 1'b1;
                    if (cnt_r != '0) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else if (idx_r + 1'b1 < len_r) begin
                        idx_r <= idx_r + 1'b1;
                        state_r <= ST_WR_SETUP;
                    end else if (ctrl_r[fsc_pkg::CTRL_OP_LSB +: 2] == fsc_pkg::OP_SEQ_WAIT) begin
                        if (ctrl_r[fsc_pkg::CTRL_TGL_BIT]) begin
                            poll_rd_r <= 1'b1;
                            byte_address_lines <= seq_addr_r[idx_r];
                            chip_sel_n <= 1'b0;
                            out_en_n <= 1'b0;
                            cnt_r <= cyc(fsc_pkg::ACC_CYC);
                            state_r <= ST_RD_ACC;
                        end else begin
                            cnt_r <= cyc(fsc_pkg::BUSY_CYC + fsc_pkg::SYNC_LAT);
                            state_r <= ST_BUSY_DLY;
                        end
                    end else begin
                        done_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_BUSY_DLY: begin
                    if (cnt_r == '0) begin
                        state_r <= ST_WAIT_RDY;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_WAIT_RDY: begin
                    if (rdy_sync) begin
                        done_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_RST_LOW: begin
                    if (cnt_r == '0) begin
                        flash_reset_n <= 1'b1;
                        cnt_r <= cyc(fsc_pkg::RH_CYC);
                        state_r <= ST_RST_REC;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_RST_REC: begin
                    if (cnt_r == '0) begin
                        done_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: test/fsc_ctrl_sva.sv
// checker for the flash sequence controller ports
`timescale 1ns/1ps
`default_nettype none
module fsc_ctrl_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [fsc_pkg::ADDR_W-1:0] byte_address_lines,
    input wire logic [fsc_pkg::DATA_W-1:0] byte_data_out,
    input wire logic byte_data_oe_n,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic flash_reset_n
);
    localparam int RST_LOW = 50;
    logic [7:0] rst_cnt_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ***
    // properties
    // ***
    // counts cycles of the flash reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt_r <= 8'h00;
        end else begin
            rst_cnt_r <= flash_reset_n ? 8'h00 : rst_cnt_r + 8'h01;
        end
    end
    property p_oe_excl; !byte_data_oe_n |-> out_en_n; endproperty
    property p_rd_cs; !out_en_n |-> !chip_sel_n && write_en_n; endproperty
    property p_we_cs; !write_en_n |-> !chip_sel_n && !byte_data_oe_n; endproperty
    property p_we_width; $fell(write_en_n) |-> (!write_en_n) [*5] ##1 write_en_n; endproperty
    property p_we_hold; !write_en_n |-> $stable(byte_address_lines) && $stable(byte_data_out);
    endproperty
    property p_idle_addr; chip_sel_n |-> $stable(byte_address_lines); endproperty
    property p_rst_len; $rose(flash_reset_n) |-> rst_cnt_r == RST_LOW; endproperty
    property p_wait; psel && penable && !pready |=> pready; endproperty
    property p_pulse; pready |=> !pready; endproperty
    a_oe_excl: assert property (p_oe_excl) else $error("read strobe while driving data");
    a_rd_cs: assert property (p_rd_cs) else $error("read strobe without select");
    a_we_cs: assert property (p_we_cs) else $error("write strobe without select");
    a_we_width: assert property (p_we_width) else $error("write pulse width");
    a_we_hold: assert property (p_we_hold) else $error("address or data moved");
    a_idle_addr: assert property (p_idle_addr) else $error("idle address moved");
    a_rst_len: assert property (p_rst_len) else $error("reset pulse length");
    a_wait: assert property (p_wait) else $error("no answer after one wait");
    a_pulse: assert property (p_pulse) else $error("ready held too long");
    c_write: cover property ($rose(write_en_n));
    c_read: cover property ($rose(out_en_n));
    c_rst: cover property ($rose(flash_reset_n));
    c_err: cover property (pslverr);
endmodule
bind fsc_ctrl fsc_ctrl_sva u_sva (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .byte_address_lines, .byte_data_out, .byte_data_oe_n, .chip_sel_n, .out_en_n,
    .write_en_n, .flash_reset_n);
`default_nettype wire

// File: test/fsc_flash_model.sv
// behavioural boot-sector flash device on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module fsc_flash_model #(
    parameter logic [7:0] UNL1 = 8'h5A,
    parameter logic [7:0] UNL2 = 8'hA5,
    parameter logic [7:0] PRG = 8'h11,
    parameter logic [7:0] ERS = 8'h22,
    parameter logic [7:0] SEC = 8'h33,
    parameter logic [7:0] CHP = 8'h44
) (
    input wire logic [18:0] addr,
    input wire logic [7:0] dq_in,
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rst_n,
    output logic [7:0] dq_out,
    output logic dq_oe_n,
    output logic rb_oe_n
);
    // ***
    // array, sequencer and status
    // ***
    logic [7:0] mem [0:524287];
    logic [7:0] last_d = 8'h00;
    logic [7:0] rd_val;
    logic busy = 1'b0;
    logic tgl = 1'b0;
    wire rd_ok;
    realtime busy_until = 0;
    int idx = 0;
    function automatic int sect(input logic [18:0] a);
        if (a < 19'h7_0000) return int'(a[18:16]);
        if (a < 19'h7_8000) return 7;
        if (a < 19'h7_A000) return 8;
        if (a < 19'h7_C000) return 9;
        return 10;
    endfunction
    task automatic start_op(input realtime t);
        busy_until = $realtime + t;
        idx = 0;
    endtask
    initial for (int i = 0; i < 524288; i++) mem[i] = 8'hFF;
    always #5 busy = rst_n && ($realtime < busy_until);
    always @(negedge rst_n) begin
        busy_until = 0;
        idx = 0;
    end
    always @(posedge we_n) begin
        if (!cs_n && rst_n && !busy) begin
            case (idx)
                0: idx = (dq_in == UNL1) ? 1 : 0;
                1: idx = (dq_in == UNL2) ? 2 : 0;
                2: idx = (dq_in == PRG) ? 3 : (dq_in == ERS) ? 4 : 0;
                3: begin
                    mem[addr] = mem[addr] & dq_in;
                    last_d = dq_in;
                    start_op(300.0);
                end
                default: begin
                    for (int i = 0; i < 524288; i++) begin
                        if (dq_in == CHP || (dq_in == SEC && sect(19'(i)) == sect(addr))) mem[i] = 8'hFF;
                    end
                    last_d = 8'hFF;
                    start_op(5000.0);
                end
            endcase
        end
    end
    always @(negedge oe_n) if (busy) tgl = !tgl;
    assign #70 rd_ok = !cs_n && !oe_n;
    assign dq_oe_n = !(!cs_n && !oe_n && rst_n);
    assign rd_val = busy ? {~last_d[7], tgl, 6'h00} : mem[addr];
    // not yet valid data shows the inverse rather than a stale byte
    assign dq_out = (rd_ok && !dq_oe_n) ? rd_val : ~rd_val;
    assign rb_oe_n = !busy;
endmodule
`default_nettype wire

// File: test/test_boot_sector_flash_command_control.sv
// testbench for the flash sequence controller against the flash model
`timescale 1ns/1ps
`default_nettype none
module test_boot_sector_flash_command_control;
    // arbitrary command codes shared with the model
    localparam logic [7:0] UNL1 = 8'h5A, UNL2 = 8'hA5, PRG = 8'h11, ERS = 8'h22;
    localparam logic [7:0] SEC = 8'h33, CHP = 8'h44;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic pready, pslverr, e, dq_oe_n, cs_n, oe_n, we_n, frst_n, rb_oe_n, ctl_oe_n;
    logic [18:0] fa;
    logic [7:0] do_c, do_f, dq, bus_last = 8'h00;
    int n_fail = 0, check_count = 0, seed = 43;
    // ***
    // clock, wire resolution, instances
    // ***
    always #5 pclk = ~pclk;
    assign dq = !ctl_oe_n ? do_c : !dq_oe_n ? do_f : ~bus_last;
    always @(posedge pclk) if (!ctl_oe_n || !dq_oe_n) bus_last <= dq;
    // ready pin is driven straight from the model: reads high while not busy
    fsc_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .byte_address_lines(fa), .byte_data_out(do_c), .byte_data_oe_n(ctl_oe_n),
        .byte_data_in(dq), .chip_sel_n(cs_n), .out_en_n(oe_n), .write_en_n(we_n),
        .flash_reset_n(frst_n), .ready_busy_out(rb_oe_n));
    fsc_flash_model #(.UNL1(UNL1), .UNL2(UNL2), .PRG(PRG), .ERS(ERS), .SEC(SEC), .CHP(CHP))
        flash (.addr(fa), .dq_in(dq), .cs_n, .oe_n, .we_n, .rst_n(frst_n), .dq_out(do_f),
        .dq_oe_n, .rb_oe_n);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) n_fail++;
    endtask
    // start an operation with standby kept on, then poll for done
    task automatic run(input logic [1:0] op, input logic tg);
        int n;
        n = 0;
        apb(1'b1, fsc_pkg::OFF_CTRL, {27'h0, tg, 1'b1, op, 1'b1});
        do begin
            apb(1'b0, fsc_pkg::OFF_STAT, 32'h0000_0000);
            n++;
        end while (q[fsc_pkg::STAT_DONE_BIT] !== 1'b1 && n < 2000);
        if (n >= 2000) n_fail++;
    endtask
    task automatic cmd(input logic [18:0] a, input logic [7:0] c, input logic [7:0] d,
                       input logic [1:0] op, input logic tg);
        logic [7:0] v [4];
        v = '{UNL1, UNL2, c, d};
        foreach (v[i]) apb(1'b1, fsc_pkg::OFF_SEQ0 + 8'(4 * i), {5'h00, a, v[i]});
        apb(1'b1, fsc_pkg::OFF_LEN, 32'h0000_0004);
        run(op, tg);
    endtask
    task automatic fread(input logic [18:0] a, input logic [7:0] exp);
        apb(1'b1, fsc_pkg::OFF_ADDR, {13'h0, a});
        run(fsc_pkg::OP_READ, 1'b0);
        check({24'h0, q[15:8]}, {24'h0, exp});
    endtask
    initial begin
        #400_000;
        n_fail++;
        report_and_stop();
    end
    initial begin
        logic [18:0] aa [4];
        logic [7:0] dd [4];
        logic [18:0] bt [3];
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, fsc_pkg::OFF_CTRL, 32'h0000_0000);
        check(q, fsc_pkg::CTRL_RST);
        apb(1'b0, fsc_pkg::OFF_LEN, 32'h0000_0000);
        check(q, fsc_pkg::LEN_RST);
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        check({31'h0, e}, 32'h0000_0001);
        apb(1'b0, 8'h40, 32'h0000_0000);
        check(q, 32'h0000_0000);
        check({31'h0, cs_n}, 32'h0000_0001);
        apb(1'b1, fsc_pkg::OFF_CTRL, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        check({31'h0, cs_n}, 32'h0000_0000);
        for (int i = 0; i < 4; i++) begin
            aa[i] = {i[2:0], 16'($random(seed))};
            dd[i] = 8'($random(seed));
            cmd(aa[i], PRG, dd[i], fsc_pkg::OP_SEQ_WAIT, i[0]);
            fread(aa[i], dd[i]);
        end
        cmd(aa[2], PRG, 8'h0F, fsc_pkg::OP_SEQ_WAIT, 1'b1);
        fread(aa[2], dd[2] & 8'h0F);
        cmd(aa[0], ERS, SEC, fsc_pkg::OP_SEQ_WAIT, 1'b0);
        fread(aa[0], 8'hFF);
        fread(aa[1], dd[1]);
        bt = '{19'h6_FFFF, 19'h7_7FFF, 19'h7_8000};
        foreach (bt[j]) cmd(bt[j], PRG, 8'h00, fsc_pkg::OP_SEQ_WAIT, 1'b0);
        cmd(19'h7_0000, ERS, SEC, fsc_pkg::OP_SEQ_WAIT, 1'b1);
        foreach (bt[j]) fread(bt[j], (j == 1) ? 8'hFF : 8'h00);
        cmd(aa[1], ERS, CHP, fsc_pkg::OP_SEQ, 1'b0);
        check({31'h0, q[fsc_pkg::STAT_RDY_BIT]}, 32'h0000_0000);
        apb(1'b1, fsc_pkg::OFF_ADDR, {13'h0, aa[1]});
        run(fsc_pkg::OP_READ, 1'b0);
        check({31'h0, q[15]}, 32'h0000_0000);
        run(fsc_pkg::OP_RESET, 1'b0);
        check({31'h0, q[fsc_pkg::STAT_RDY_BIT]}, 32'h0000_0001);
        fread(aa[1], 8'hFF);
        report_and_stop();
    end
endmodule
`default_nettype wire
